// >>> meas_seq_pkg.sv
// Register map, field layouts, timing constants and types of the sequencer
package meas_seq_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CFG_OFS     = 8'h00;
  localparam logic [7:0] SHUNT_OFS   = 8'h04;
  localparam logic [7:0] BUS_OFS     = 8'h08;
  localparam logic [7:0] POWER_OFS   = 8'h0c;
  localparam logic [7:0] CURRENT_OFS = 8'h10;
  localparam logic [7:0] CAL_OFS     = 8'h14;
  localparam logic [7:0] STATUS_OFS  = 8'h18;

  // ==========================================================
  // Fields
  localparam int unsigned MODE_SHUNT_BIT = 0;
  localparam int unsigned MODE_BUS_BIT   = 1;
  localparam int unsigned MODE_CONT_BIT  = 2;
  localparam int unsigned READY_BIT      = 0;
  localparam int unsigned BUSY_BIT       = 1;

  typedef struct packed {
    logic [2:0] avg;
    logic [2:0] bus_ct;
    logic [2:0] shunt_ct;
    logic [2:0] mode;
  } cfg_t;

  localparam int unsigned CFG_W = $bits(cfg_t);
  localparam cfg_t CFG_RESET = '{avg: 3'h0, bus_ct: 3'h4, shunt_ct: 3'h4,
                                 mode: 3'h7};

  typedef struct packed {
    logic signed [15:0] shunt;
    logic        [15:0] bus;
    logic signed [15:0] current;
    logic signed [15:0] power;
  } result_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAKE  = 2'b01,
    ST_SHUNT = 2'b11,
    ST_BUS   = 2'b10
  } state_t;

  // ==========================================================
  // Timing: conversion times in us, 140 us .. 8244 us
  localparam logic [13:0] CT_US [8] = '{14'h008c, 14'h00cc, 14'h014c,
                                        14'h024c, 14'h044c, 14'h0844,
                                        14'h103c, 14'h2034};
  localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                           4'h7, 4'h8, 4'h9, 4'ha};
  localparam int unsigned CLK_NS     = 50;
  localparam int unsigned NS_PER_US  = 1000;
  localparam int unsigned NS_PER_MS  = 1000000;
  localparam int unsigned WAKE_MS    = 40;
  localparam int unsigned CYC_PER_US = NS_PER_US / CLK_NS;
  localparam int unsigned WAKE_CYC   = WAKE_MS * (NS_PER_MS / CLK_NS);

  // ==========================================================
  // Widths and arithmetic scaling
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ACC_W     = 26;
  localparam int unsigned CNT_W     = 24;
  localparam int unsigned SET_W     = 11;
  localparam int unsigned CUR_SHIFT = 11;
  localparam int unsigned PWR_SHIFT = 13;

endpackage

// >>> meas_seq.sv
// Conversion sequencer with averaging, current and power arithmetic
//
// Function
// - Continuous mode repeats shunt then bus conversions
// - Current computed after each shunt sample
// - Power computed after each bus sample
// - Uncalibrated device reports zero current and power
// - Averaging above one accumulates, not outputs
// - Averaged results load all outputs of the measured channels together
// - Outputs hold until next complete result
// - Result reads never disturb conversions
// - Arithmetic runs beside conversions, adds no time
// - Shunt-only and bus-only modes exist
// - Triggered write runs one averaged set
// - Power-down halts; 40 ms settle after wake
// - Registers stay accessible during power-down
// - Power-down holds until active mode written
// - Ready flag set when cycle completes
// - Configuration write clears ready, except power-down
// - Status read clears ready flag
// - Conversion times 140 us to 8.244 ms
// - Shunt and bus times chosen independently
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module meas_seq #(
  parameter int unsigned CYC_PER_US = meas_seq_pkg::CYC_PER_US,
  parameter int unsigned WAKE_CYC   = meas_seq_pkg::WAKE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] shunt_adc,
  input  wire logic [15:0] bus_adc,
  output logic             front_end_on,
  output logic             adc_busy,
  output logic             adc_on_bus,
  output logic             conv_ready
);

  // ==========================================================
  // Parameter checks
  if (CYC_PER_US < 1 || WAKE_CYC < 1 ||
      CYC_PER_US * meas_seq_pkg::CT_US[7] >=
      (32'h1 << meas_seq_pkg::CNT_W)) begin
    $error("meas_seq: timing parameters out of range");
  end

  meas_seq_pkg::cfg_t    cfg_reg;
  meas_seq_pkg::result_t res_reg;
  meas_seq_pkg::state_t  state_reg;
  logic [15:0]                       cal_reg;
  logic                              cal_set_reg;
  logic                              ready_reg;
  logic [meas_seq_pkg::CNT_W-1:0]    cnt_reg;
  logic [meas_seq_pkg::SET_W-1:0]    set_cnt_reg;
  logic [15:0]                       shunt_meta_reg, shunt_sync_reg;
  logic [15:0]                       bus_meta_reg, bus_sync_reg;
  logic                              calc_valid_reg, calc_bus_reg;
  logic                              calc_last_reg;
  logic [15:0]                       samp_reg;
  logic signed [15:0]                last_cur_reg;
  logic signed [meas_seq_pkg::ACC_W-1:0] acc_shunt_reg, acc_bus_reg;
  logic signed [meas_seq_pkg::ACC_W-1:0] acc_cur_reg, acc_pwr_reg;
  logic [31:0]                       prdata_reg;

  // ==========================================================
  // APB decode
  logic               acc_wr, acc_rd, cfg_wr, stat_rd, mapped;
  meas_seq_pkg::cfg_t new_cfg;
  logic [15:0]        new_cfg_raw;
  logic [15:0]        new_cal;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
    merge16 = {strb[1] ? wd[15:8] : old_v[15:8],
               strb[0] ? wd[7:0]  : old_v[7:0]};
  endfunction

  function automatic logic is_pd(input logic [2:0] m);
    is_pd = !m[meas_seq_pkg::MODE_SHUNT_BIT] &&
            !m[meas_seq_pkg::MODE_BUS_BIT];
  endfunction

  function automatic meas_seq_pkg::state_t first_st(input logic [2:0] m);
    first_st = m[meas_seq_pkg::MODE_SHUNT_BIT] ? meas_seq_pkg::ST_SHUNT
                                              : meas_seq_pkg::ST_BUS;
  endfunction

  assign acc_wr  = psel && penable && pwrite;
  assign acc_rd  = psel && penable && !pwrite;
  assign cfg_wr  = acc_wr && paddr == meas_seq_pkg::CFG_OFS;
  assign stat_rd = acc_rd && paddr == meas_seq_pkg::STATUS_OFS;
  assign mapped  = paddr inside {meas_seq_pkg::CFG_OFS,
                                 meas_seq_pkg::SHUNT_OFS,
                                 meas_seq_pkg::BUS_OFS,
                                 meas_seq_pkg::POWER_OFS,
                                 meas_seq_pkg::CURRENT_OFS,
                                 meas_seq_pkg::CAL_OFS,
                                 meas_seq_pkg::STATUS_OFS};
  assign new_cfg_raw = merge16(16'(cfg_reg), pwdata, pstrb);
  // Upper lanes beyond the field layout are dropped on purpose
  assign new_cfg = meas_seq_pkg::cfg_t'(
                     new_cfg_raw[meas_seq_pkg::CFG_W-1:0]);
  assign new_cal = merge16(cal_reg, pwdata, pstrb);
  // Zero wait states: reads never stall the sequencer
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_reg;

  // ==========================================================
  // Configuration and calibration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= meas_seq_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg_reg <= new_cfg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_reg     <= 16'h0000;
      cal_set_reg <= 1'b0;
    end else if (acc_wr && paddr == meas_seq_pkg::CAL_OFS) begin
      cal_reg     <= new_cal;
      cal_set_reg <= 1'b1;
    end
  end

  // Read data latched in setup so it is a flop output in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        meas_seq_pkg::CFG_OFS:     prdata_reg <= 32'(cfg_reg);
        meas_seq_pkg::SHUNT_OFS:   prdata_reg <= 32'(res_reg.shunt);
        meas_seq_pkg::BUS_OFS:     prdata_reg <= 32'(res_reg.bus);
        meas_seq_pkg::POWER_OFS:   prdata_reg <= 32'(res_reg.power);
        meas_seq_pkg::CURRENT_OFS: prdata_reg <= 32'(res_reg.current);
        meas_seq_pkg::CAL_OFS:     prdata_reg <= 32'(cal_reg);
        meas_seq_pkg::STATUS_OFS: begin
          prdata_reg <= 32'h0000_0000;
          prdata_reg[meas_seq_pkg::READY_BIT] <= ready_reg;
          prdata_reg[meas_seq_pkg::BUSY_BIT]  <=
            state_reg != meas_seq_pkg::ST_IDLE;
        end
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Front-end sample synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shunt_meta_reg <= 16'h0000;
      shunt_sync_reg <= 16'h0000;
      bus_meta_reg   <= 16'h0000;
      bus_sync_reg   <= 16'h0000;
    end else begin
      shunt_meta_reg <= shunt_adc;
      shunt_sync_reg <= shunt_meta_reg;
      bus_meta_reg   <= bus_adc;
      bus_sync_reg   <= bus_meta_reg;
    end
  end

  // ==========================================================
  // Sequencer
  logic [2:0]                     ct_sel;
  logic [meas_seq_pkg::CNT_W-1:0] conv_lim;
  logic [meas_seq_pkg::SET_W-1:0] avg_max;
  logic                           conv_done, set_end, avg_last, stop;

  assign ct_sel   = (state_reg == meas_seq_pkg::ST_BUS) ? cfg_reg.bus_ct
                                                        : cfg_reg.shunt_ct;
  assign conv_lim = meas_seq_pkg::CNT_W'(
                      meas_seq_pkg::CT_US[ct_sel] * CYC_PER_US);
  assign conv_done = (state_reg == meas_seq_pkg::ST_SHUNT ||
                      state_reg == meas_seq_pkg::ST_BUS) &&
                     cnt_reg == conv_lim - 1'b1;
  assign set_end  = conv_done && (state_reg == meas_seq_pkg::ST_BUS ||
                    !cfg_reg.mode[meas_seq_pkg::MODE_BUS_BIT]);
  assign avg_max  = meas_seq_pkg::SET_W'((32'h1 <<
                      meas_seq_pkg::AVG_SHIFT[cfg_reg.avg]) - 1);
  assign avg_last = set_cnt_reg == avg_max;
  assign stop     = set_end && avg_last &&
                    !cfg_reg.mode[meas_seq_pkg::MODE_CONT_BIT];

  // Reset starts in the settle phase, as after leaving power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= meas_seq_pkg::ST_WAKE;
      cnt_reg   <= '0;
    end else if (cfg_wr) begin
      if (is_pd(new_cfg.mode)) begin
        state_reg <= meas_seq_pkg::ST_IDLE;
        cnt_reg   <= '0;
      end else if (state_reg == meas_seq_pkg::ST_WAKE) begin
        state_reg <= meas_seq_pkg::ST_WAKE;
        cnt_reg   <= cnt_reg;
      end else if (is_pd(cfg_reg.mode)) begin
        state_reg <= meas_seq_pkg::ST_WAKE;
        cnt_reg   <= '0;
      end else begin
        state_reg <= first_st(new_cfg.mode);
        cnt_reg   <= '0;
      end
    end else begin
      unique case (state_reg)
        meas_seq_pkg::ST_IDLE: cnt_reg <= '0;
        meas_seq_pkg::ST_WAKE: begin
          if (cnt_reg == meas_seq_pkg::CNT_W'(WAKE_CYC - 1)) begin
            state_reg <= first_st(cfg_reg.mode);
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        meas_seq_pkg::ST_SHUNT, meas_seq_pkg::ST_BUS: begin
          if (conv_done) begin
            cnt_reg <= '0;
            if (stop) begin
              state_reg <= meas_seq_pkg::ST_IDLE;
            end else if (state_reg == meas_seq_pkg::ST_SHUNT &&
                         cfg_reg.mode[meas_seq_pkg::MODE_BUS_BIT]) begin
              state_reg <= meas_seq_pkg::ST_BUS;
            end else begin
              state_reg <= first_st(cfg_reg.mode);
            end
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_cnt_reg <= '0;
    end else if (cfg_wr || (set_end && avg_last)) begin
      set_cnt_reg <= '0;
    end else if (set_end) begin
      set_cnt_reg <= set_cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // Arithmetic stage, one cycle behind each conversion end
  logic signed [32:0] cur_prod, pwr_prod;
  logic signed [15:0] cur_val, pwr_val;
  logic signed [meas_seq_pkg::ACC_W-1:0] s_shunt, s_bus, s_cur, s_pwr;
  logic                                  load_out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calc_valid_reg <= 1'b0;
      calc_bus_reg   <= 1'b0;
      calc_last_reg  <= 1'b0;
      samp_reg       <= 16'h0000;
    end else begin
      calc_valid_reg <= conv_done && !cfg_wr;
      calc_bus_reg   <= state_reg == meas_seq_pkg::ST_BUS;
      calc_last_reg  <= set_end && avg_last;
      samp_reg       <= (state_reg == meas_seq_pkg::ST_BUS) ? bus_sync_reg
                                                          : shunt_sync_reg;
    end
  end

  assign cur_prod = 33'(signed'(samp_reg) * signed'({1'b0, cal_reg}));
  assign pwr_prod = 33'(last_cur_reg * signed'({1'b0, samp_reg}));
  assign cur_val  = cal_set_reg ? cur_prod[meas_seq_pkg::CUR_SHIFT +: 16]
                                : 16'sh0000;
  assign pwr_val  = cal_set_reg ? pwr_prod[meas_seq_pkg::PWR_SHIFT +: 16]
                                : 16'sh0000;

  assign s_shunt = acc_shunt_reg + (calc_bus_reg ? '0 :
                     meas_seq_pkg::ACC_W'(signed'(samp_reg)));
  assign s_cur   = acc_cur_reg + (calc_bus_reg ? '0 :
                     meas_seq_pkg::ACC_W'(cur_val));
  assign s_bus   = acc_bus_reg + (calc_bus_reg ?
                     meas_seq_pkg::ACC_W'(signed'({1'b0, samp_reg})) : '0);
  assign s_pwr   = acc_pwr_reg + (calc_bus_reg ?
                     meas_seq_pkg::ACC_W'(pwr_val) : '0);
  assign load_out = calc_valid_reg && calc_last_reg && !cfg_wr;

  function automatic logic [15:0] avg16(
      input logic signed [meas_seq_pkg::ACC_W-1:0] s,
      input logic [2:0] code);
    logic signed [meas_seq_pkg::ACC_W-1:0] q;
    q     = s >>> meas_seq_pkg::AVG_SHIFT[code];
    avg16 = q[15:0];
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cur_reg <= 16'sh0000;
    end else if (calc_valid_reg && !calc_bus_reg) begin
      last_cur_reg <= cur_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_shunt_reg <= '0;
      acc_bus_reg   <= '0;
      acc_cur_reg   <= '0;
      acc_pwr_reg   <= '0;
    end else if (cfg_wr || load_out) begin
      acc_shunt_reg <= '0;
      acc_bus_reg   <= '0;
      acc_cur_reg   <= '0;
      acc_pwr_reg   <= '0;
    end else if (calc_valid_reg) begin
      acc_shunt_reg <= s_shunt;
      acc_bus_reg   <= s_bus;
      acc_cur_reg   <= s_cur;
      acc_pwr_reg   <= s_pwr;
    end
  end

  // Channels not measured in the selected mode keep their old values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_reg <= '0;
    end else if (load_out) begin
      if (cfg_reg.mode[meas_seq_pkg::MODE_SHUNT_BIT]) begin
        res_reg.shunt   <= avg16(s_shunt, cfg_reg.avg);
        res_reg.current <= avg16(s_cur, cfg_reg.avg);
      end
      if (cfg_reg.mode[meas_seq_pkg::MODE_BUS_BIT]) begin
        res_reg.bus   <= avg16(s_bus, cfg_reg.avg);
        res_reg.power <= avg16(s_pwr, cfg_reg.avg);
      end
    end
  end

  // Set wins over clear in the same cycle; a load in a status read's setup cycle is cleared unread by its access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
    end else if (load_out) begin
      ready_reg <= 1'b1;
    end else if ((cfg_wr && !is_pd(new_cfg.mode)) || stat_rd) begin
      ready_reg <= 1'b0;
    end
  end

  assign front_end_on = !is_pd(cfg_reg.mode);
  assign adc_busy     = state_reg == meas_seq_pkg::ST_SHUNT ||
                        state_reg == meas_seq_pkg::ST_BUS;
  assign adc_on_bus   = state_reg == meas_seq_pkg::ST_BUS;
  assign conv_ready   = ready_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_set_a: assert property (load_out |=> ready_reg)
    else $error("ready flag not set after result load");
  cal_zero_a: assert property (load_out && !cal_set_reg &&
      cfg_reg.mode == 3'h7 |=> res_reg.current == 0 && res_reg.power == 0)
    else $error("uncalibrated result not zero");
  out_hold_a: assert property (!load_out |=> $stable(res_reg))
    else $error("result changed without a load");
  pd_halt_a: assert property (is_pd(cfg_reg.mode) |->
      state_reg == meas_seq_pkg::ST_IDLE)
    else $error("sequencer active in power-down");
  cfg_clear_a: assert property (cfg_wr && !is_pd(new_cfg.mode) |=>
      !ready_reg)
    else $error("configuration write left ready set");
  stat_clear_a: assert property (stat_rd && !load_out |=> !ready_reg)
    else $error("status read left ready set");
  trig_stop_a: assert property (conv_done && stop && !cfg_wr |=>
      state_reg == meas_seq_pkg::ST_IDLE ##1
      (state_reg == meas_seq_pkg::ST_IDLE || $past(cfg_wr)))
    else $error("triggered set did not stop");
  shunt_bus_a: assert property (state_reg == meas_seq_pkg::ST_SHUNT &&
      conv_done && cfg_reg.mode == 3'h7 && !cfg_wr |=>
      state_reg == meas_seq_pkg::ST_BUS && cnt_reg == 0)
    else $error("bus conversion did not follow shunt");
  calc_next_a: assert property (conv_done && !cfg_wr |=>
      calc_valid_reg && calc_bus_reg == $past(adc_on_bus) &&
      samp_reg == ($past(adc_on_bus) ? $past(bus_sync_reg)
                                     : $past(shunt_sync_reg)))
    else $error("arithmetic stage missed a sample");

  cont_load_c: cover property (load_out && cfg_reg.mode == 3'h7);
  trig_stop_c: cover property (conv_done && stop);
  wake_done_c: cover property (state_reg == meas_seq_pkg::ST_WAKE ##1
                               state_reg == meas_seq_pkg::ST_SHUNT);
  clash_c: cover property (load_out && stat_rd);

endmodule

// >>> fe_model.sv
// Behavioural front end that hands converter samples to the sequencer
`timescale 1ns/1ns
module fe_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        front_end_on,
  input  wire logic        adc_busy,
  input  wire logic        adc_on_bus,
  input  wire logic        wobble,
  input  wire logic [15:0] shunt_val,
  input  wire logic [15:0] bus_val,
  output logic      [15:0] shunt_adc,
  output logic      [15:0] bus_adc
);
  logic busy_q;
  logic bus_q;
  logic alt;
  // ==========================================================
  // Sample launch
  // New sample one cycle after busy rises or the channel switches: stable long
  // before the sequencer's synchroniser takes it at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q    <= 1'b0;
      bus_q     <= 1'b0;
      alt       <= 1'b0;
      shunt_adc <= 16'h0000;
      bus_adc   <= 16'h0000;
    end else begin
      busy_q <= adc_busy;
      bus_q  <= adc_on_bus;
      if (!front_end_on) begin
        // Unpowered inputs carry no valid level
        shunt_adc <= ~shunt_adc;
        bus_adc   <= ~bus_adc;
      end else if (adc_busy && (!busy_q || adc_on_bus != bus_q)) begin
        if (adc_on_bus) begin
          bus_adc <= bus_val;
        end else begin
          // Optional +2 on every second sample exercises averaging
          shunt_adc <= shunt_val + {14'h0000, wobble & alt, 1'b0};
          alt       <= ~alt;
        end
      end
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench for the measurement conversion sequencer
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned WAKE_P = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] shunt_adc, bus_adc, shunt_val, bus_val;
  logic        wobble, front_end_on, adc_busy, adc_on_bus, conv_ready;
  logic        err;
  int          n_mismatch, check_count, cycles;

  meas_seq #(.CYC_PER_US(1), .WAKE_CYC(WAKE_P)) meas_seq_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shunt_adc(shunt_adc), .bus_adc(bus_adc),
    .front_end_on(front_end_on), .adc_busy(adc_busy),
    .adc_on_bus(adc_on_bus), .conv_ready(conv_ready));
  fe_model fe_model_i (
    .pclk(pclk), .presetn(presetn), .front_end_on(front_end_on),
    .adc_busy(adc_busy), .adc_on_bus(adc_on_bus), .wobble(wobble),
    .shunt_val(shunt_val), .bus_val(bus_val),
    .shunt_adc(shunt_adc), .bus_adc(bus_adc));

  always #25 pclk = ~pclk;

  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Return mid-cycle so callers see what the access edge updated
    @(negedge pclk);
  endtask
  task automatic rchk(input string name, input logic [7:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask
  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (conv_ready !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check("conv_ready", 32'h1, {31'h0, conv_ready});
  endtask
  // Counts cycles with a conversion running; a halted device shows none
  task automatic quiet(input int len);
    int hits;
    hits = 0;
    repeat (len) begin
      @(posedge pclk);
      if (adc_busy !== 1'b0) hits++;
    end
    check("busy_cycles", 32'h0, hits);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rchk("config", meas_seq_pkg::CFG_OFS, 32'h0000_0127);
    rchk("cal", meas_seq_pkg::CAL_OFS, 32'h0000_0000);
    rchk("unmapped", 8'h1c, 32'h0000_0000);
    check("slverr", 32'h1, {31'h0, err});
  endtask
  task automatic t_uncal;
    wait_ready(3000);
    apb(1'b1, meas_seq_pkg::SHUNT_OFS, 32'h0000_ffff);
    rchk("shunt", meas_seq_pkg::SHUNT_OFS, 32'h0000_0100);
    rchk("bus", meas_seq_pkg::BUS_OFS, 32'h0000_2000);
    rchk("current", meas_seq_pkg::CURRENT_OFS, 32'h0);
    rchk("power", meas_seq_pkg::POWER_OFS, 32'h0);
  endtask
  task automatic t_trig;
    apb(1'b1, meas_seq_pkg::CAL_OFS, 32'h0000_1000);
    apb(1'b1, meas_seq_pkg::CFG_OFS, 32'h0000_0003);
    check("ready_cleared", 32'h0, {31'h0, conv_ready});
    wait_ready(1000);
    rchk("current", meas_seq_pkg::CURRENT_OFS, 32'h0000_0200);
    rchk("power", meas_seq_pkg::POWER_OFS, 32'h0000_0200);
    rchk("status", meas_seq_pkg::STATUS_OFS, 32'h0000_0001);
    check("ready_read", 32'h0, {31'h0, conv_ready});
    quiet(300);
    shunt_val <= 16'h0080;
    apb(1'b1, meas_seq_pkg::CFG_OFS, 32'h0000_0003);
    wait_ready(1000);
    rchk("shunt", meas_seq_pkg::SHUNT_OFS, 32'h0000_0080);
    rchk("current", meas_seq_pkg::CURRENT_OFS, 32'h0000_0100);
    rchk("power", meas_seq_pkg::POWER_OFS, 32'h0000_0100);
  endtask
  task automatic t_avg;
    shunt_val <= 16'h0100;
    wobble <= 1'b1;
    apb(1'b1, meas_seq_pkg::CFG_OFS, 32'h0000_0203);
    repeat (400) @(posedge pclk);
    rchk("shunt_held", meas_seq_pkg::SHUNT_OFS, 32'h0000_0080);
    wait_ready(1500);
    rchk("shunt", meas_seq_pkg::SHUNT_OFS, 32'h0000_0101);
    rchk("current", meas_seq_pkg::CURRENT_OFS, 32'h0000_0202);
    rchk("power", meas_seq_pkg::POWER_OFS, 32'h0000_0202);
    wobble <= 1'b0;
  endtask
  task automatic t_pdown;
    int n;
    n = 0;
    apb(1'b1, meas_seq_pkg::CFG_OFS, 32'h0000_0000);
    check("ready_kept", 32'h1, {31'h0, conv_ready});
    check("front_end", 32'h0, {31'h0, front_end_on});
    quiet(300);
    apb(1'b1, meas_seq_pkg::CAL_OFS, 32'h0000_0800);
    rchk("cal", meas_seq_pkg::CAL_OFS, 32'h0000_0800);
    bus_val <= 16'h1000;
    apb(1'b1, meas_seq_pkg::CFG_OFS, 32'h0000_0006);
    while (adc_busy !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check("wake", 32'h1, {31'h0, n >= WAKE_P - 1 && n <= WAKE_P + 2});
    check("on_bus", 32'h1, {31'h0, adc_on_bus});
    wait_ready(1000);
    rchk("bus", meas_seq_pkg::BUS_OFS, 32'h0000_1000);
    rchk("shunt_kept", meas_seq_pkg::SHUNT_OFS, 32'h0000_0101);
    apb(1'b1, meas_seq_pkg::CFG_OFS, 32'h0000_0005);
    wait_ready(1000);
    rchk("current", meas_seq_pkg::CURRENT_OFS, 32'h0000_0100);
    rchk("bus_kept", meas_seq_pkg::BUS_OFS, 32'h0000_1000);
  endtask
  // Single-channel shots with distinct times: busy spans time plus one
  task automatic t_time;
    int n;
    apb(1'b1, meas_seq_pkg::CFG_OFS, 32'h0000_0009);
    n = 0;
    while (adc_busy === 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    check("shunt_time", meas_seq_pkg::CT_US[1] + 1, n);
    apb(1'b1, meas_seq_pkg::CFG_OFS, 32'h0000_0082);
    n = 0;
    while (adc_busy === 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    check("bus_time", meas_seq_pkg::CT_US[2] + 1, n);
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 5500 cycles the scenarios need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      finish_test;
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    shunt_val = 16'h0100;
    bus_val = 16'h2000;
    wobble = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_uncal;
    t_trig;
    t_avg;
    t_pdown;
    t_time;
    finish_test;
  end
endmodule
